// >>> hw/sac_pkg.sv
// sac_pkg: register map, field positions, reset values and types of the
// converter configuration and accumulator block.
// assumes: an 8-bit special-function register port and a single system clock.
`default_nettype none
package sac_pkg;
  // register addresses on the special-function register port
  localparam logic [7:0] ADDR_ACC_CFG = 8'hba;
  localparam logic [7:0] ADDR_CONV_CFG = 8'hbc;
  localparam logic [7:0] ADDR_RES_LOW = 8'hbd;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hbe;
  // reset values
  localparam logic [7:0] CONV_CFG_RESET = 8'hf8;
  localparam logic [7:0] ACC_CFG_RESET = 8'h00;
  localparam logic [15:0] ACC_RESET = 16'h0000;
  // converter_configuration fields
  localparam int DIV_LSB = 3;
  localparam int EIGHT_BIT_POS = 2;
  localparam int TRACK_POS = 1;
  localparam int GAIN_POS = 0;
  // accumulator_configuration fields
  localparam int TWELVE_BIT_POS = 7;
  localparam int ACC_EN_POS = 6;
  localparam int SHIFT_LSB = 3;
  localparam int REPEAT_LSB = 0;
  // timing: delayed tracking adds this many conversion-clock cycles
  localparam logic [1:0] TRACK_DELAY_TICKS = 2'h3;
  // low-power oscillator rate feeding the divider in burst mode
  localparam int LP_OSC_MHZ = 20;
  // codes
  localparam logic [2:0] SHIFT_MAX_RIGHT = 3'h3;
  localparam logic [2:0] SHIFT_LEFT = 3'h4;
  localparam logic [2:0] REPEAT_MAX = 3'h5;
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [4:0] LJ_SHIFT_8 = 5'h08;
  localparam logic [4:0] LJ_SHIFT_10 = 5'h06;
  localparam logic [4:0] LJ_SHIFT_12 = 5'h04;

  typedef struct packed {
    logic [4:0] divider;
    logic eightBit;
    logic trackMode;
    logic gainUnity;
    logic twelveBit;
    logic [2:0] shiftSel;
    logic [2:0] repeatSel;
    logic burst;
  } sac_cfg_t;

  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_TRACK = 3'b010,
    SAC_CONV = 3'b100
  } sac_state_t;
endpackage
`default_nettype wire

// >>> hw/sac_config_accumulator.sv
// sac_config_accumulator: conversion clock divider, mode selection,
// conversion sequencing and 16-bit result accumulator for the SAR converter.
// assumes: register port and all inputs synchronous to clock; lpOscTick is a
// one-cycle pulse per low-power oscillator period; the core answers coreStart
// with one coreDone pulse carrying a right-justified result.
//
// Functional notes
// RQ1: conversion clock is source divided by field plus one
// RQ2: source is system clock, or oscillator in burst
// RQ3: eight-bit bit set gives 8-bit, else 10-bit
// RQ4: delayed tracking waits 3 conversion clocks before converting
// RQ5: gain bit clear gives 0.5, set gives unity
// RQ6: twelve-bit bit selects 12-bit resolution
// RQ7: accumulate bit adds results outside burst, else replaces
// RQ8: software clears sum by writing zero to both bytes
// RQ9: accumulate enable bit always reads zero
// RQ10: shift field right-shifts 0-3 or left-justifies result
// RQ11: burst repeat field gives 1 to 64 conversions
// RQ12: software keeps repeat field zero outside burst
// RQ13: burst enable picks burst or single operation
// RQ14: completion flag set per conversion or burst
// RQ15: high byte write loads accumulator upper byte
// RQ16: settings take effect at next start of conversion; the accumulate enable bit is read live when each result lands outside burst
// RQ17: reserved shift and repeat codes act as zero
`default_nettype none
module sac_config_accumulator (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrRead,
  output logic [7:0] sfrRdata,
  input wire logic converterEnable,
  input wire logic burstModeEnable,
  input wire logic startOfConversion,
  input wire logic lpOscTick,
  input wire logic flagClear,
  input wire logic coreDone,
  input wire logic [11:0] coreResult,
  output logic coreStart,
  output logic conversionClockTick,
  output logic [1:0] resolutionSel,
  output logic pgaGainUnity,
  output logic conversionCompleteFlag,
  output logic busy
);
  sac_pkg::sac_state_t state_reg, state_next;
  sac_pkg::sac_cfg_t activeCfg_reg, activeCfg_next, liveCfg;
  logic [7:0] convCfg_reg, convCfg_next, accCfg_reg, accCfg_next;
  logic [15:0] acc_reg, acc_next;
  logic [4:0] divCount_reg, divCount_next;
  logic [1:0] trackCount_reg, trackCount_next;
  logic [6:0] burstCount_reg, burstCount_next, burstTarget;
  logic [7:0] sfrRdata_next;
  logic coreStart_next, convTick_next, flag_next, flagSet, sourceTick, accept;
  logic [1:0] res_next;
  logic gain_next;
  logic [15:0] formatted, sample;
  logic [4:0] ljShift;

  // configuration registers as software sees them
  always_comb begin
    convCfg_next = convCfg_reg;
    accCfg_next = accCfg_reg;
    if (sfrWrite && sfrAddr == sac_pkg::ADDR_CONV_CFG) begin
      convCfg_next = sfrWdata;
    end
    if (sfrWrite && sfrAddr == sac_pkg::ADDR_ACC_CFG) begin
      accCfg_next = sfrWdata;
    end
    liveCfg.divider = convCfg_reg[sac_pkg::DIV_LSB +: 5];
    liveCfg.eightBit = convCfg_reg[sac_pkg::EIGHT_BIT_POS];
    liveCfg.trackMode = convCfg_reg[sac_pkg::TRACK_POS];
    liveCfg.gainUnity = convCfg_reg[sac_pkg::GAIN_POS];
    liveCfg.twelveBit = accCfg_reg[sac_pkg::TWELVE_BIT_POS];
    liveCfg.shiftSel = accCfg_reg[sac_pkg::SHIFT_LSB +: 3];
    if (liveCfg.shiftSel > sac_pkg::SHIFT_LEFT) begin
      liveCfg.shiftSel = 3'h0; // [RQ17]
    end
    liveCfg.repeatSel = accCfg_reg[sac_pkg::REPEAT_LSB +: 3];
    if (liveCfg.repeatSel > sac_pkg::REPEAT_MAX || !burstModeEnable) begin
      liveCfg.repeatSel = 3'h0; // [RQ17] [RQ12]
    end
    liveCfg.burst = burstModeEnable; // [RQ13]
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      convCfg_reg <= sac_pkg::CONV_CFG_RESET;
      accCfg_reg <= sac_pkg::ACC_CFG_RESET;
    end else begin
      convCfg_reg <= convCfg_next;
      accCfg_reg <= accCfg_next;
    end
  end

  // sequencing, divider and accumulator
  always_comb begin
    state_next = state_reg;
    activeCfg_next = activeCfg_reg;
    acc_next = acc_reg;
    divCount_next = divCount_reg;
    trackCount_next = trackCount_reg;
    burstCount_next = burstCount_reg;
    res_next = resolutionSel;
    gain_next = pgaGainUnity;
    coreStart_next = 1'b0;
    convTick_next = 1'b0;
    flagSet = 1'b0;
    sample = {4'h0, coreResult};
    burstTarget = (activeCfg_reg.repeatSel == 3'h0) ? 7'h01 :
                  (7'h01 << (activeCfg_reg.repeatSel + 3'h1)); // [RQ11]
    sourceTick = activeCfg_reg.burst ? lpOscTick : 1'b1; // [RQ2]
    accept = startOfConversion && state_reg == sac_pkg::SAC_IDLE &&
             (converterEnable || burstModeEnable);
    if (sourceTick) begin
      if (divCount_reg >= activeCfg_reg.divider) begin
        divCount_next = 5'h00; // [RQ1]
        convTick_next = 1'b1;
      end else begin
        divCount_next = divCount_reg + 5'h01;
      end
    end
    // software writes; a result landing in the same cycle overrides them
    if (sfrWrite && sfrAddr == sac_pkg::ADDR_RES_HIGH) begin
      acc_next[15:8] = sfrWdata; // [RQ15] [RQ8]
    end
    if (sfrWrite && sfrAddr == sac_pkg::ADDR_RES_LOW) begin
      acc_next[7:0] = sfrWdata; // [RQ8]
    end
    case (state_reg)
      sac_pkg::SAC_IDLE: begin
        if (accept) begin
          activeCfg_next = liveCfg; // [RQ16]
          res_next = liveCfg.twelveBit ? sac_pkg::RES_12 :
                     (liveCfg.eightBit ? sac_pkg::RES_8 : sac_pkg::RES_10); // [RQ3] [RQ6]
          gain_next = liveCfg.gainUnity; // [RQ5]
          divCount_next = 5'h00;
          convTick_next = 1'b0;
          burstCount_next = 7'h00;
          trackCount_next = 2'h0;
          if (liveCfg.trackMode) begin
            state_next = sac_pkg::SAC_TRACK; // [RQ4]
          end else begin
            state_next = sac_pkg::SAC_CONV; // [RQ4]
            coreStart_next = 1'b1;
          end
        end
      end
      sac_pkg::SAC_TRACK: begin
        if (conversionClockTick) begin
          trackCount_next = trackCount_reg + 2'h1;
          if (trackCount_next == sac_pkg::TRACK_DELAY_TICKS) begin
            state_next = sac_pkg::SAC_CONV; // [RQ4]
            coreStart_next = 1'b1;
          end
        end
      end
      sac_pkg::SAC_CONV: begin
        if (coreDone) begin
          if (activeCfg_reg.burst) begin
            acc_next = (burstCount_reg == 7'h00) ? sample : acc_reg + sample; // [RQ11]
          end else begin
            acc_next = accCfg_reg[sac_pkg::ACC_EN_POS] ? acc_reg + sample : sample; // [RQ7]
          end
          if (activeCfg_reg.burst && burstCount_reg + 7'h01 != burstTarget) begin
            burstCount_next = burstCount_reg + 7'h01; // [RQ13]
            trackCount_next = 2'h0;
            if (activeCfg_reg.trackMode) begin
              state_next = sac_pkg::SAC_TRACK;
            end else begin
              coreStart_next = 1'b1;
            end
          end else begin
            flagSet = 1'b1; // [RQ14]
            state_next = sac_pkg::SAC_IDLE;
          end
        end
      end
      default: begin
        state_next = sac_pkg::SAC_IDLE;
      end
    endcase
    // a completion in the clearing cycle still sets the flag
    flag_next = flagSet ? 1'b1 : (flagClear ? 1'b0 : conversionCompleteFlag); // [RQ14]
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= sac_pkg::SAC_IDLE;
      activeCfg_reg <= '0;
      acc_reg <= sac_pkg::ACC_RESET;
      divCount_reg <= 5'h00;
      trackCount_reg <= 2'h0;
      burstCount_reg <= 7'h00;
      resolutionSel <= sac_pkg::RES_10;
      pgaGainUnity <= 1'b0;
      coreStart <= 1'b0;
      conversionClockTick <= 1'b0;
      conversionCompleteFlag <= 1'b0;
      busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      activeCfg_reg <= activeCfg_next;
      acc_reg <= acc_next;
      divCount_reg <= divCount_next;
      trackCount_reg <= trackCount_next;
      burstCount_reg <= burstCount_next;
      resolutionSel <= res_next;
      pgaGainUnity <= gain_next;
      coreStart <= coreStart_next;
      conversionClockTick <= convTick_next;
      conversionCompleteFlag <= flag_next;
      busy <= state_next != sac_pkg::SAC_IDLE;
    end
  end

  // read path; format follows the settings latched at the last start
  always_comb begin
    ljShift = (resolutionSel == sac_pkg::RES_12) ? sac_pkg::LJ_SHIFT_12 :
              ((resolutionSel == sac_pkg::RES_8) ? sac_pkg::LJ_SHIFT_8 : sac_pkg::LJ_SHIFT_10);
    if (activeCfg_reg.shiftSel == sac_pkg::SHIFT_LEFT) begin
      formatted = acc_reg << ljShift; // [RQ10]
    end else if (activeCfg_reg.shiftSel <= sac_pkg::SHIFT_MAX_RIGHT) begin
      formatted = acc_reg >> activeCfg_reg.shiftSel; // [RQ10]
    end else begin
      formatted = acc_reg;
    end
    sfrRdata_next = sfrRdata;
    if (sfrRead) begin
      case (sfrAddr)
        sac_pkg::ADDR_CONV_CFG: sfrRdata_next = convCfg_reg;
        sac_pkg::ADDR_ACC_CFG: begin
          sfrRdata_next = accCfg_reg;
          sfrRdata_next[sac_pkg::ACC_EN_POS] = 1'b0; // [RQ9]
        end
        sac_pkg::ADDR_RES_HIGH: sfrRdata_next = formatted[15:8];
        sac_pkg::ADDR_RES_LOW: sfrRdata_next = formatted[7:0];
        default: sfrRdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sfrRdata <= 8'h00;
    end else begin
      sfrRdata <= sfrRdata_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_divide_by_two: assert property (state_reg != sac_pkg::SAC_IDLE && !activeCfg_reg.burst &&
      activeCfg_reg.divider == 5'h01 && conversionClockTick && !coreDone
      |=> !conversionClockTick ##1 conversionClockTick) // [RQ1]
    else $error("conversion clock not source over divider plus one");
  chk_burst_source: assert property (activeCfg_reg.burst && !lpOscTick && !accept
      |=> !conversionClockTick) // [RQ2]
    else $error("burst divider ticked without oscillator");
  chk_res_latch: assert property (accept |=> resolutionSel == ($past(liveCfg.twelveBit) ?
      sac_pkg::RES_12 : ($past(liveCfg.eightBit) ? sac_pkg::RES_8 : sac_pkg::RES_10))) // [RQ3]
    else $error("resolution not taken at start");
  chk_track_delay: assert property (accept && liveCfg.trackMode |=> !coreStart [*3]) // [RQ4]
    else $error("delayed tracking started early");
  chk_normal_start: assert property (accept && !liveCfg.trackMode |=> coreStart) // [RQ4]
    else $error("normal tracking did not start at once");
  chk_gain_hold: assert property (state_reg != sac_pkg::SAC_IDLE |=> $stable(pgaGainUnity)) // [RQ16]
    else $error("gain changed during a conversion");
  chk_accum_add: assert property (state_reg == sac_pkg::SAC_CONV && coreDone &&
      !activeCfg_reg.burst && accCfg_reg[sac_pkg::ACC_EN_POS]
      |=> acc_reg == $past(acc_reg) + $past(sample)) // [RQ7]
    else $error("accumulate did not add");
  chk_single_replace: assert property (state_reg == sac_pkg::SAC_CONV && coreDone &&
      !activeCfg_reg.burst && !accCfg_reg[sac_pkg::ACC_EN_POS]
      |=> acc_reg == $past(sample)) // [RQ7]
    else $error("single result not replaced");
  chk_ae_reads_zero: assert property (sfrRead && sfrAddr == sac_pkg::ADDR_ACC_CFG
      |=> !sfrRdata[sac_pkg::ACC_EN_POS]) // [RQ9]
    else $error("accumulate enable read back nonzero");
  chk_flag_sticky: assert property (conversionCompleteFlag && !flagClear
      |=> conversionCompleteFlag) // [RQ14]
    else $error("completion flag dropped without clear");
  chk_high_write: assert property (sfrWrite && sfrAddr == sac_pkg::ADDR_RES_HIGH && !coreDone
      |=> acc_reg[15:8] == $past(sfrWdata)) // [RQ15]
    else $error("high byte write not loaded");
  chk_repeat_bound: assert property (burstCount_reg < 7'h40 && burstTarget <= 7'h40) // [RQ17]
    else $error("burst count beyond 64");
endmodule
`default_nettype wire

// >>> tb/sac_testbench.sv
// testbench: self-checking bench for the converter configuration and accumulator.
// assumes: the bench plays the analog core and the low-power oscillator itself.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, sfrWrite, sfrRead, converterEnable, burstModeEnable;
  logic startOfConversion, lpOscTick, flagClear, coreDone, coreStart, conversionClockTick;
  logic pgaGainUnity, conversionCompleteFlag, busy;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata;
  logic [11:0] coreResult;
  logic [1:0] resolutionSel;
  logic [15:0] e;
  int n_errors, tests_run, cycles, nStarts, tickCnt, ticksPre, gapCnt, lastGap, gapPre;
  int pend, lpCnt;

  sac_config_accumulator uut (.clock(clock), .rstn(rstn), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
    .converterEnable(converterEnable), .burstModeEnable(burstModeEnable),
    .startOfConversion(startOfConversion), .lpOscTick(lpOscTick), .flagClear(flagClear),
    .coreDone(coreDone), .coreResult(coreResult), .coreStart(coreStart),
    .conversionClockTick(conversionClockTick), .resolutionSel(resolutionSel),
    .pgaGainUnity(pgaGainUnity), .conversionCompleteFlag(conversionCompleteFlag),
    .busy(busy));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic end_sim();
    $display("mismatches %0d of %0d comparisons", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // core answers two cycles after each start; oscillator ticks every third cycle
  always @(negedge clock) begin
    coreDone = 1'b0;
    lpCnt = (lpCnt + 1) % 3;
    lpOscTick = (lpCnt == 0);
    if (conversionClockTick === 1'b1) begin
      tickCnt++;
      lastGap = gapCnt;
      gapCnt = 1;
    end else begin
      gapCnt++;
    end
    if (coreStart === 1'b1) begin
      nStarts++;
      if (nStarts == 1) begin
        ticksPre = tickCnt;
        gapPre = lastGap;
      end
      pend = 2;
    end else if (pend > 0) begin
      pend--;
      coreDone = (pend == 0);
    end
    cycles++;
    // whole run needs well under a thousand cycles
    if (cycles > 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clock);
    sfrWrite = 1'b0;
    // let an edge pass so a following write never re-raises the strobe at once
    @(negedge clock);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clock);
    sfrRead = 1'b0;
    @(negedge clock);
    chk(16'(sfrRdata), 16'(exp));
  endtask

  // mid: converter_configuration written while busy, zero for none
  task automatic conv(input logic brst, input int n, input logic [7:0] mid);
    int w;
    burstModeEnable = brst;
    startOfConversion = 1'b1;
    // clear counts only after the monitor has taken this edge's sample
    #1;
    nStarts = 0;
    tickCnt = 0;
    @(negedge clock);
    startOfConversion = 1'b0;
    if (mid != 8'h00) begin
      wr(8'hbc, mid);
      chk(16'(busy), 16'h0001);
    end
    w = 0;
    while (conversionCompleteFlag !== 1'b1 && w < 3000) begin
      @(negedge clock);
      w++;
    end
    chk(16'(conversionCompleteFlag), 16'h0001);
    chk(16'(nStarts), 16'(n));
    flagClear = 1'b1;
    @(negedge clock);
    flagClear = 1'b0;
    @(negedge clock);
    chk(16'(conversionCompleteFlag), 16'h0000);
  endtask

  task automatic t_regs();
    rchk(8'hbc, sac_pkg::CONV_CFG_RESET);
    rchk(8'hba, sac_pkg::ACC_CFG_RESET);
    chk(16'(resolutionSel), 16'(sac_pkg::RES_10));
    chk(16'(pgaGainUnity), 16'h0000);
    rchk(8'h55, 8'h00);
    wr(8'hba, 8'h78);
    rchk(8'hba, 8'h38);
    wr(8'hbc, 8'h13);
    rchk(8'hbc, 8'h13);
    converterEnable = 1'b0;
    startOfConversion = 1'b1;
    @(negedge clock);
    startOfConversion = 1'b0;
    @(negedge clock);
    chk(16'(busy), 16'h0000);
    converterEnable = 1'b1;
  endtask

  task automatic t_accum();
    wr(8'hba, 8'h00);
    wr(8'hbc, 8'h18);
    coreResult = 12'h123;
    conv(1'b0, 1, 8'h00);
    chk(16'(ticksPre), 16'h0000);
    coreResult = 12'h0f0;
    conv(1'b0, 1, 8'h00);
    rchk(8'hbd, 8'hf0);
    wr(8'hba, 8'h40);
    coreResult = 12'h123;
    conv(1'b0, 1, 8'h00);
    conv(1'b0, 1, 8'h00);
    rchk(8'hbd, 8'h36);
    rchk(8'hbe, 8'h03);
    // format is latched at start, so each shift code needs its own conversion
    coreResult = 12'h336;
    for (int s = 0; s < 8; s++) begin
      wr(8'hba, {2'b00, 3'(s), 3'b000});
      conv(1'b0, 1, 8'h00);
      e = (s < 4) ? (16'h0336 >> s) : ((s == 4) ? 16'hcd80 : 16'h0336);
      rchk(8'hbd, e[7:0]);
      rchk(8'hbe, e[15:8]);
    end
    wr(8'hbe, 8'h5a);
    rchk(8'hbe, 8'h5a);
    wr(8'hbe, 8'h00);
    wr(8'hbd, 8'h00);
    rchk(8'hbd, 8'h00);
    rchk(8'hbe, 8'h00);
  endtask

  task automatic t_delay();
    wr(8'hbc, 8'h1f);
    wr(8'hba, 8'h80);
    conv(1'b0, 1, 8'h00);
    chk(16'(ticksPre), 16'(sac_pkg::TRACK_DELAY_TICKS));
    chk(16'(gapPre), 16'h0004);
    chk(16'(resolutionSel), 16'(sac_pkg::RES_12));
    chk(16'(pgaGainUnity), 16'h0001);
    wr(8'hba, 8'h00);
    conv(1'b0, 1, 8'h18);
    chk(16'(ticksPre), 16'h0003);
    chk(16'(resolutionSel), 16'(sac_pkg::RES_8));
    conv(1'b0, 1, 8'h00);
    chk(16'(ticksPre), 16'h0000);
    chk(16'(resolutionSel), 16'(sac_pkg::RES_10));
    // divide by two under delayed tracking
    wr(8'hbc, 8'h0a);
    conv(1'b0, 1, 8'h00);
    chk(16'(ticksPre), 16'(sac_pkg::TRACK_DELAY_TICKS));
    chk(16'(gapPre), 16'h0002);
  endtask

  task automatic t_burst();
    int n;
    // burst runs with the converter itself disabled
    converterEnable = 1'b0;
    wr(8'hbc, 8'h0a);
    conv(1'b1, 1, 8'h00);
    chk(16'(gapPre), 16'h0006);
    wr(8'hbc, 8'h08);
    coreResult = 12'h0ab;
    for (int r = 0; r < 7; r++) begin
      n = (r == 0 || r == 6) ? 1 : (2 << r);
      wr(8'hba, {5'b00000, 3'(r)});
      conv(1'b1, n, 8'h00);
      e = 16'(n * 12'h0ab);
      wr(8'hba, 8'h00);
      rchk(8'hbd, e[7:0]);
      rchk(8'hbe, e[15:8]);
    end
    converterEnable = 1'b1;
  endtask

  initial begin
    rstn = 1'b0;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    converterEnable = 1'b1;
    burstModeEnable = 1'b0;
    startOfConversion = 1'b0;
    lpOscTick = 1'b0;
    flagClear = 1'b0;
    coreDone = 1'b0;
    coreResult = 12'h000;
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    t_regs();
    t_accum();
    t_delay();
    t_burst();
    end_sim();
  end
endmodule
`default_nettype wire
